// ### verilog/sram_ctrl_regs.vh
// Constants and timing for the static memory controller
`ifndef SRAM_CTRL_REGS_VH
`define SRAM_CTRL_REGS_VH
`define ADDR_W 13
`define DATA_W 8
`define CLK_PERIOD_PS 4000
// Times in picoseconds
`define T_RC_PS 150000
`define T_WC_PS 150000
`define T_CW_PS 100000
`define T_WP_PS 90000
`define T_DW_PS 60000
`define T_REC_STROBE_PS 10000
`define T_REC_HISEL_PS 15000
`define T_AA_PS 150000
`define T_OHZ_PS 50000
// Cycle counts, minimums rounded up, maxima waited in full
`define CYC_RC ((`T_RC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_WC ((`T_WC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_CW ((`T_CW_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_WP ((`T_WP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DW ((`T_DW_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_REC_STROBE ((`T_REC_STROBE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_REC_HISEL ((`T_REC_HISEL_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_AA ((`T_AA_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_OHZ ((`T_OHZ_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ### verilog/sram_ctrl.v
// Host-side controller for an asynchronous 8K x 8 static memory
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_regs.vh"
module sram_ctrl (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // User request
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [`ADDR_W-1:0] req_addr,
    input wire [`DATA_W-1:0] req_wdata,
    // User answer
    output reg rsp_valid,
    output reg [`DATA_W-1:0] rsp_rdata,
    // Retention control
    input wire retain_req,
    output reg retain_active,
    // Memory pins
    output reg [`ADDR_W-1:0] mem_addr,
    output reg primary_select_n,
    output reg secondary_select,
    output reg write_strobe_n,
    output reg output_drive_n,
    input wire [`DATA_W-1:0] mem_data_in,
    output reg [`DATA_W-1:0] mem_data_out,
    output reg mem_data_oe_n
);

    // ****************************************
    // States and timing
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RD = 3'h1;
    localparam [2:0] ST_RD_END = 3'h2;
    localparam [2:0] ST_WR = 3'h3;
    localparam [2:0] ST_WR_REC = 3'h4;
    localparam [2:0] ST_RET = 3'h5;
    localparam [2:0] ST_RET_EXIT = 3'h6;
    // Cycle counts at full integer width
    localparam integer AA_I = `CYC_AA;
    localparam integer RC_I = `CYC_RC;
    localparam integer OHZ_I = `CYC_OHZ;
    localparam integer WP_I = (`CYC_WP > `CYC_CW) ? `CYC_WP : `CYC_CW;
    localparam integer WP_DW_I = (WP_I > `CYC_DW) ? WP_I : `CYC_DW;
    localparam integer WR_I = `CYC_REC_STROBE;
    localparam integer WC_REST_I = `CYC_WC - WP_DW_I - 1;
    // Same counts cut to the counter width
    localparam [7:0] N_AA = AA_I[7:0];
    localparam [7:0] N_RC = RC_I[7:0];
    localparam [7:0] N_OHZ = OHZ_I[7:0];
    localparam [7:0] N_WP = WP_I[7:0];
    localparam [7:0] N_WP_DW = WP_DW_I[7:0];
    localparam [7:0] N_WR = WR_I[7:0];
    localparam [7:0] N_WC_REST = WC_REST_I[7:0];

    // ****************************************
    // Data pin capture
    // ****************************************
    // Three-stage input capture for the asynchronous data pins
    reg [`DATA_W-1:0] din_s1_q, din_s2_q, din_s3_q;
    reg [`DATA_W-1:0] din_q;
    always @(posedge sys_clk) begin
        din_s1_q <= mem_data_in;
        din_s2_q <= din_s1_q;
        din_s3_q <= din_s2_q;
    end

    // New pin value counts once the last two stages agree
    always @(posedge sys_clk) begin
        if (din_s2_q == din_s3_q)
            din_q <= din_s3_q;
    end

    reg [2:0] state_q;
    reg [7:0] cnt_q;
    reg [7:0] hz_cnt_q;

    // ****************************************
    // Request handshake
    // ****************************************
    // Ready only when a request is really taken: idle, no retention, port released
    assign req_ready = (state_q == ST_IDLE) && !retain_req && (hz_cnt_q == 8'h00);

    // ****************************************
    // Helpers
    // ****************************************
    // Counter has run at least the given number of cycles
    function at_least;
        input [7:0] count;
        input [7:0] limit;
        begin
            at_least = (count >= limit);
        end
    endfunction

    // ****************************************
    // Main sequencer
    // ****************************************
    always @(posedge sys_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            hz_cnt_q <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            retain_active <= 1'b0;
            mem_addr <= 13'h0000;
            primary_select_n <= 1'b1;
            secondary_select <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            mem_data_out <= 8'h00;
            mem_data_oe_n <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            if (hz_cnt_q != 8'h00)
                hz_cnt_q <= hz_cnt_q - 8'h01;
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 8'h00;
                    if (retain_req) begin
                        // Deselect by both selects at retention entry
                        primary_select_n <= 1'b1;
                        secondary_select <= 1'b0;
                        write_strobe_n <= 1'b1;
                        output_drive_n <= 1'b1;
                        mem_data_oe_n <= 1'b1;
                        retain_active <= 1'b1;
                        state_q <= ST_RET;
                    end else if (req_valid && hz_cnt_q == 8'h00) begin
                        // Address goes out in the same cycle as the select and the write strobe or output drive
                        mem_addr <= req_addr;
                        primary_select_n <= 1'b0;
                        secondary_select <= 1'b1;
                        if (req_write) begin
                            // Drive disabled, bus turned around before data
                            output_drive_n <= 1'b1;
                            write_strobe_n <= 1'b0;
                            mem_data_out <= req_wdata;
                            mem_data_oe_n <= 1'b0;
                            state_q <= ST_WR;
                        end else begin
                            write_strobe_n <= 1'b1;
                            output_drive_n <= 1'b0;
                            mem_data_oe_n <= 1'b1;
                            state_q <= ST_RD;
                        end
                    end else begin
                        // Keep the select as it was (off from reset to the first access), idle, port undriven
                        output_drive_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                    end
                end
                ST_RD: begin
                    cnt_q <= cnt_q + 8'h01;
                    // Sample after access time plus input capture depth
                    if (cnt_q == N_AA + 8'h03) begin
                        rsp_rdata <= din_q;
                        rsp_valid <= 1'b1;
                        output_drive_n <= 1'b1;
                        state_q <= ST_RD_END;
                    end
                end
                ST_RD_END: begin
                    cnt_q <= cnt_q + 8'h01;
                    // Keep strobe high and finish the read cycle time
                    if (at_least(cnt_q, N_RC)) begin
                        // Memory output may still drive for its turn-off time
                        hz_cnt_q <= N_OHZ;
                        state_q <= ST_IDLE;
                        cnt_q <= 8'h00;
                    end
                end
                ST_WR: begin
                    cnt_q <= cnt_q + 8'h01;
                    // End write by the strobe after pulse and data overlap
                    if (cnt_q == N_WP_DW) begin
                        write_strobe_n <= 1'b1;
                        cnt_q <= 8'h00;
                        state_q <= ST_WR_REC;
                    end
                end
                ST_WR_REC: begin
                    cnt_q <= cnt_q + 8'h01;
                    // Hold address and data past strobe-ended recovery
                    if (at_least(cnt_q, N_WR) && at_least(cnt_q, N_WC_REST)) begin
                        mem_data_oe_n <= 1'b1;
                        rsp_valid <= 1'b1;
                        state_q <= ST_IDLE;
                        cnt_q <= 8'h00;
                    end
                end
                ST_RET: begin
                    // Low secondary select gates all other inputs while retained
                    if (!retain_req) begin
                        secondary_select <= 1'b1;
                        cnt_q <= 8'h00;
                        state_q <= ST_RET_EXIT;
                    end
                end
                ST_RET_EXIT: begin
                    cnt_q <= cnt_q + 8'h01;
                    // Wait one read cycle before the next access
                    if (at_least(cnt_q, N_RC)) begin
                        retain_active <= 1'b0;
                        primary_select_n <= 1'b0;
                        state_q <= ST_IDLE;
                        cnt_q <= 8'h00;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### tb/sram_ctrl_props.sv
// Checker for the memory pin sequencing of the controller
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_regs.vh"
module sram_ctrl_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Observed ports
    input wire logic rsp_valid,
    input wire logic retain_active,
    input wire logic [`ADDR_W-1:0] mem_addr,
    input wire logic primary_select_n,
    input wire logic secondary_select,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [`DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [7:0] wp_q;
    logic [7:0] rc_q;
    wire mem_drives = !primary_select_n && secondary_select && write_strobe_n && !output_drive_n;
    // Strobe low length and time since high select came back
    always_ff @(posedge sys_clk) begin
        wp_q <= (reset || write_strobe_n) ? 8'h00 : wp_q + 8'h01;
        rc_q <= reset ? 8'hff : !secondary_select ? 8'h00 : (rc_q == 8'hff) ? rc_q : rc_q + 8'h01;
    end
    property p_no_clash; !mem_data_oe_n |-> !mem_drives; endproperty
    a_no_clash: assert property (p_no_clash) else $error("host drives against memory");
    property p_read_we; (!primary_select_n && !output_drive_n) |-> write_strobe_n; endproperty
    a_read_we: assert property (p_read_we) else $error("strobe low in read");
    property p_addr_hold; (!write_strobe_n && !$past(write_strobe_n)) |-> $stable(mem_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
    property p_recov; $rose(write_strobe_n) |-> $stable(mem_addr)[*3]; endproperty
    a_recov: assert property (p_recov) else $error("address moved in recovery");
    property p_pulse; $rose(write_strobe_n) |-> wp_q >= `CYC_WP; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    property p_wdata;
        !write_strobe_n |-> !mem_data_oe_n && ($past(write_strobe_n) || $stable(mem_data_out));
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data not held");
    property p_retain; retain_active && !secondary_select |-> primary_select_n; endproperty
    a_retain: assert property (p_retain) else $error("selected in retention");
    property p_exit; $fell(primary_select_n) |-> rc_q >= `CYC_RC; endproperty
    a_exit: assert property (p_exit) else $error("access too soon after retention");
    c_write: cover property ($rose(write_strobe_n));
    c_read: cover property (rsp_valid && write_strobe_n);
    c_exit: cover property ($fell(retain_active));
endmodule
bind sram_ctrl sram_ctrl_props props_u (.sys_clk, .reset, .rsp_valid, .retain_active, .mem_addr,
    .primary_select_n, .secondary_select, .write_strobe_n, .output_drive_n, .mem_data_out, .mem_data_oe_n);
`default_nettype wire

// ### tb/sram_model.sv
// Behavioural model of the 8K x 8 static memory
`timescale 1ns/10ps
`default_nettype none
module sram_model (
    // Pattern clock and pins
    input wire logic clk,
    input wire logic [12:0] addr,
    input wire logic sel_n,
    input wire logic sel2,
    input wire logic we_n,
    input wire logic oe_n,
    // Host side of the data line
    input wire logic [7:0] host_d,
    input wire logic host_oe_n,
    output logic [7:0] bus
);
    logic [7:0] mem [0:8191];
    logic [7:0] idle_q = 8'h00;
    wire wr = !sel_n && sel2 && !we_n;
    wire rd = !sel_n && sel2 && we_n && !oe_n;
    // Store at the end of the write only
    always @(negedge wr) mem[addr] = host_d;
    // Undriven line flips every cycle
    always @(posedge clk) idle_q <= ~bus;
    assign bus = !host_oe_n ? host_d : rd ? mem[addr] : idle_q;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench for the static memory controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0] req_wdata = 8'h00;
    wire req_ready, rsp_valid, retain_active, primary_select_n, secondary_select, write_strobe_n;
    wire output_drive_n, mem_data_oe_n;
    wire [7:0] rsp_rdata, mem_data_out, mem_data_in;
    wire [12:0] mem_addr;
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #2 sys_clk = ~sys_clk;
    sram_ctrl dut_u (.sys_clk, .reset, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .rsp_valid, .rsp_rdata, .retain_req, .retain_active, .mem_addr, .primary_select_n,
        .secondary_select, .write_strobe_n, .output_drive_n, .mem_data_in, .mem_data_out, .mem_data_oe_n);
    sram_model mem_u (.clk(sys_clk), .addr(mem_addr), .sel_n(primary_select_n), .sel2(secondary_select),
        .we_n(write_strobe_n), .oe_n(output_drive_n), .host_d(mem_data_out), .host_oe_n(mem_data_oe_n),
        .bus(mem_data_in));
    // ****************
    // Shared tasks
    // ****************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, held until taken, then wait for the answer
    task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(negedge sys_clk);
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        while (rsp_valid !== 1'b1) @(negedge sys_clk);
        if (!w) check(rsp_rdata, d);
    endtask
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Back-to-back writes at both address ends, then read back
    task automatic t_fill;
        logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        logic [7:0] d [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) xfer(1'b1, a[i], d[i]);
        for (int i = 0; i < 4; i++) xfer(1'b0, a[i], d[i]);
    endtask
    // Overwrite one word, word at the top address unchanged
    task automatic t_over;
        xfer(1'b1, 13'h0000, 8'h3c);
        xfer(1'b0, 13'h0000, 8'h3c);
        xfer(1'b0, 13'h1fff, 8'h5a);
    endtask
    // Retention: requests refused, both selects off, contents kept
    task automatic t_retain;
        @(posedge sys_clk);
        retain_req <= 1'b1;
        repeat (20) @(negedge sys_clk);
        check({6'h00, retain_active, req_ready}, 8'h02);
        check({6'h00, primary_select_n, secondary_select}, 8'h02);
        @(posedge sys_clk);
        retain_req <= 1'b0;
        @(negedge sys_clk);
        while (retain_active !== 1'b0) @(negedge sys_clk);
        xfer(1'b0, 13'h1555, 8'h00);
    endtask
    // Cycle ceiling
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_fill;
        t_over;
        t_retain;
        finish_test;
    end
endmodule
`default_nettype wire
